//--- design/wdt_pkg.sv
// ============================================================
// Summary of operation
// - with external rc clock selected, oscillator output pin carries system clock divided by 8
// - watchdog oscillator runs during power-down; an option can disable it
// - power-down entered only by the sleep instruction; core halts there
// - memory, registers and port states held unchanged during power-down
// - sleep clears watchdog; it counts on osc clock, stops on system clock
// - sleep sets power-down flag and clears time-out flag
// - wake on external reset, enabled port a falling edge, interrupt, watchdog overflow
// - reset wake is full reset; overflow wake sets time-out, resets pc and sp only
// - power-down flag cleared at power-up and by watchdog-clear instructions
// - per-pin falling-edge wake enables; port wake resumes after sleep
// - disabled interrupt or full stack: resume after sleep, interrupt stays pending
// - enabled interrupt with free stack: normal interrupt response after wake
// - interrupt flag already set at sleep entry is not a wake source
// - wait 1024 system clocks after any wake other than external reset before resuming
// - watchdog clock option: watchdog oscillator or system clock divided by 8
// - watchdog disabled by option: watchdog instructions do nothing; the counter still runs and its overflow still resets
// - watchdog oscillator first divided by 256 in an 8-stage counter
// - select bits 0 to 2 set extra division; all ones gives 1:128
// - time-out in normal operation resets device and sets time-out flag
// - counter and prescaler cleared by reset pin, clear instructions or sleep
// - option selects single clear or paired first/second clear instructions
// - paired mode: repeated same instruction no effect; alternation completes clear
package wdt_pkg;
  // ============================================================
  // register map
  localparam logic [1:0] ADDR_SELECT = 2'h0;
  localparam logic [1:0] ADDR_CONFIG = 2'h1;
  localparam logic [1:0] ADDR_STATUS = 2'h2;
  localparam logic [1:0] ADDR_PORTWAKE = 2'h3;
  localparam logic [7:0] SELECT_RESET = 8'h07;
  localparam int SEL_LSB = 0;
  localparam int SEL_W = 3;
  // config bits
  localparam int CFG_WDT_EN = 0;
  localparam int CFG_OSC_EN = 1;
  localparam int CFG_CLK_OSC = 2;
  localparam int CFG_PAIRED = 3;
  localparam int CFG_RC_CLK = 4;
  localparam logic [7:0] CONFIG_RESET = 8'h07;
  // status bits
  localparam int ST_PDF = 0;
  localparam int ST_TO = 1;
  localparam int ST_SLEEP = 2;
  localparam int ST_WAKING = 3;
  // ============================================================
  // timing
  localparam int WAKE_CYCLES = 1024;
  localparam int INSTR_DIV = 8;
  localparam int OSC_PREDIV_W = 8;
  localparam int PRESCALE_W = 7;
  localparam int COUNT_W = 8;
  typedef enum logic [1:0] {PM_RUN, PM_SLEEP, PM_WAKE} pm_state_e;
endpackage

//--- design/wdt_tick_if.sv
`timescale 1ns/1ns
// ============================================================
// ticks and clears between the top and the timer
interface wdt_tick_if;
  logic clear;
  logic osc_tick;
  logic instr_tick;
  logic use_osc;
  logic sleeping;
  logic [2:0] sel;
  logic overflow;
  modport ctrl (output clear, osc_tick, instr_tick, use_osc, sleeping, sel, input overflow);
  modport timer (input clear, osc_tick, instr_tick, use_osc, sleeping, sel, output overflow);
endinterface

//--- design/wdt_divider.sv
`timescale 1ns/1ns
// ============================================================
// watchdog counting chain
module wdt_divider
  import wdt_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // control
  wdt_tick_if.timer t
);
  logic [OSC_PREDIV_W-1:0] pre_q;
  logic [PRESCALE_W-1:0] ps_q;
  logic [COUNT_W-1:0] cnt_q;
  logic pre_wrap;
  logic base_tick;
  logic [PRESCALE_W:0] taps;
  logic ps_tick;
  logic ov_q;

  assign pre_wrap = t.osc_tick && (pre_q == '1);
  // system clock stops in power-down, so that source gives no ticks then
  assign base_tick = t.use_osc ? pre_wrap : (t.instr_tick && !t.sleeping);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pre_q <= '0;
    end else if (t.clear) begin
      pre_q <= '0;
    end else if (t.osc_tick) begin
      pre_q <= pre_q + 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ps_q <= '0;
    end else if (t.clear) begin
      ps_q <= '0;
    end else if (base_tick) begin
      ps_q <= ps_q + 1'b1;
    end
  end

  // tap n is a carry out of bit n-1: ticks at base rate / 2**n
  genvar i;
  generate
    for (i = 0; i <= PRESCALE_W; i++) begin : g_tap
      if (i == 0) begin : g0
        assign taps[i] = base_tick;
      end else begin : gn
        assign taps[i] = base_tick && (ps_q[i-1:0] == '1);
      end
    end
  endgenerate
  assign ps_tick = taps[t.sel];

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_q <= '0;
      ov_q <= 1'b0;
    end else if (t.clear) begin
      cnt_q <= '0;
      ov_q <= 1'b0;
    end else begin
      ov_q <= ps_tick && (cnt_q == '1);
      if (ps_tick) begin
        cnt_q <= cnt_q + 1'b1;
      end
    end
  end
  assign t.overflow = ov_q;
endmodule

//--- design/wdt_powerdown.sv
`timescale 1ns/1ns
// ============================================================
// watchdog with power-down and wake-up sequencing
module wdt_powerdown
  import wdt_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // avalon-mm slave
  input wire logic [1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // core instruction strobes
  input wire logic sleep_instr,
  input wire logic clear_watchdog_single,
  input wire logic clear_watchdog_first,
  input wire logic clear_watchdog_second,
  // wake sources
  input wire logic external_reset_pin,
  input wire logic [7:0] port_a_in,
  input wire logic irq_req,
  input wire logic irq_enabled,
  input wire logic stack_full,
  input wire logic wdt_osc_tick,
  // core control
  output logic core_halt,
  output logic hold_state,
  output logic sys_osc_run,
  output logic full_reset,
  output logic pc_sp_reset,
  output logic irq_service,
  output logic resume_next,
  output logic wdt_osc_enable,
  // oscillator output, open drain
  output logic osc_output_pin_o,
  output logic osc_output_pin_oe
);
  wdt_tick_if t ();

  logic [7:0] select_q;
  logic [7:0] config_q;
  logic [7:0] portwake_q;
  logic powerdown_flag_q;
  logic timeout_flag_q;
  logic first_done_q;
  logic second_done_q;
  logic [7:0] port_prev_q;
  logic irq_masked_q;
  logic irq_prev_q;
  logic wake_irq_q;
  logic [9:0] wake_cnt_q;
  logic [2:0] div8_q;
  logic osc_div_q;
  logic ack_q;
  logic wait_q;
  logic [31:0] rdata_q;
  logic core_halt_q, hold_q, run_q, frst_q, pcsp_q, isvc_q, rnext_q, oscen_q;
  pm_state_e state_q;

  logic wdt_en, paired, instr_tick, clr_instr, sleep_go;
  logic port_wake, irq_wake, ext_wake, wake_any;
  logic wr_sel, wr_cfg, wr_pw, wr_st;

  // ============================================================
  // instruction decode
  assign wdt_en = config_q[CFG_WDT_EN];
  assign paired = config_q[CFG_PAIRED];
  assign instr_tick = (div8_q == 3'h7) && (state_q != PM_SLEEP);
  // a completed pair, or the single instruction, when the watchdog is enabled
  assign clr_instr = wdt_en && (paired ?
      ((clear_watchdog_first && second_done_q) || (clear_watchdog_second && first_done_q)) :
      clear_watchdog_single);
  assign sleep_go = sleep_instr && (state_q == PM_RUN);

  // ============================================================
  // wake sources
  assign port_wake = |(portwake_q & port_prev_q & ~port_a_in);
  assign irq_wake = irq_req && !irq_prev_q && !irq_masked_q;
  assign ext_wake = !external_reset_pin;
  assign wake_any = port_wake || irq_wake || t.overflow;

  assign t.clear = ext_wake || clr_instr || (sleep_go && wdt_en);
  assign t.osc_tick = wdt_osc_tick && config_q[CFG_OSC_EN];
  assign t.instr_tick = instr_tick;
  assign t.use_osc = config_q[CFG_CLK_OSC];
  assign t.sleeping = (state_q == PM_SLEEP);
  assign t.sel = select_q[SEL_LSB +: SEL_W];

  wdt_divider u_div (
    .clk(clk),
    .rst(rst),
    .t(t)
  );

  // ============================================================
  // register bus: one wait cycle; a write lands on the edge that sees waitrequest low
  assign wr_sel = avs_write && ack_q && (avs_address == ADDR_SELECT);
  assign wr_cfg = avs_write && ack_q && (avs_address == ADDR_CONFIG);
  assign wr_pw = avs_write && ack_q && (avs_address == ADDR_PORTWAKE);
  assign wr_st = avs_write && ack_q && (avs_address == ADDR_STATUS);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ack_q <= 1'b0;
      wait_q <= 1'b1;
      rdata_q <= '0;
    end else begin
      ack_q <= (avs_read || avs_write) && !ack_q;
      wait_q <= !((avs_read || avs_write) && !ack_q);
      if (avs_read && !ack_q) begin
        unique case (avs_address)
          ADDR_SELECT: rdata_q <= {24'h000000, select_q};
          ADDR_CONFIG: rdata_q <= {24'h000000, config_q};
          ADDR_STATUS: rdata_q <= {28'h0000000, state_q == PM_WAKE, state_q == PM_SLEEP,
                                   timeout_flag_q, powerdown_flag_q};
          ADDR_PORTWAKE: rdata_q <= {24'h000000, portwake_q};
        endcase
      end
    end
  end
  assign avs_readdata = rdata_q;
  assign avs_waitrequest = wait_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      select_q <= SELECT_RESET;
      config_q <= CONFIG_RESET;
      portwake_q <= 8'h00;
    end else begin
      if (wr_sel) begin
        select_q <= avs_writedata[7:0];
      end
      if (wr_cfg) begin
        config_q <= avs_writedata[7:0];
      end
      if (wr_pw) begin
        portwake_q <= avs_writedata[7:0];
      end
    end
  end

  // ============================================================
  // paired clear tracking
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      first_done_q <= 1'b0;
      second_done_q <= 1'b0;
    end else if (clr_instr || ext_wake) begin
      first_done_q <= 1'b0;
      second_done_q <= 1'b0;
    end else if (wdt_en && paired) begin
      if (clear_watchdog_first) begin
        first_done_q <= 1'b1;
      end
      if (clear_watchdog_second) begin
        second_done_q <= 1'b1;
      end
    end
  end

  // ============================================================
  // status flags; the reset pin clears both first, otherwise setting events take priority
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      powerdown_flag_q <= 1'b0;
      timeout_flag_q <= 1'b0;
    end else if (ext_wake) begin
      powerdown_flag_q <= 1'b0;
      timeout_flag_q <= 1'b0;
    end else begin
      if (sleep_go && wdt_en) begin
        powerdown_flag_q <= 1'b1;
      end else if (clr_instr) begin
        powerdown_flag_q <= 1'b0;
      end
      if (t.overflow) begin
        timeout_flag_q <= 1'b1;
      end else if (sleep_go && wdt_en) begin
        timeout_flag_q <= 1'b0;
      end else if (wr_st && avs_writedata[ST_TO]) begin
        timeout_flag_q <= 1'b0;
      end
    end
  end

  // ============================================================
  // sampling of pins and the interrupt line
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      port_prev_q <= 8'hFF;
      irq_prev_q <= 1'b0;
      irq_masked_q <= 1'b0;
    end else begin
      port_prev_q <= port_a_in;
      irq_prev_q <= irq_req;
      if (sleep_go) begin
        irq_masked_q <= irq_req;
      end else if (!irq_req) begin
        irq_masked_q <= 1'b0;
      end
    end
  end

  // ============================================================
  // power state machine
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q <= PM_RUN;
      wake_cnt_q <= '0;
      wake_irq_q <= 1'b0;
    end else if (ext_wake) begin
      state_q <= PM_RUN;
      wake_cnt_q <= '0;
      wake_irq_q <= 1'b0;
    end else begin
      unique case (state_q)
        PM_RUN: begin
          if (sleep_go) begin
            state_q <= PM_SLEEP;
          end
        end
        PM_SLEEP: begin
          if (wake_any) begin
            state_q <= PM_WAKE;
            wake_cnt_q <= '0;
            wake_irq_q <= irq_wake && !port_wake && !t.overflow;
          end
        end
        PM_WAKE: begin
          wake_cnt_q <= wake_cnt_q + 1'b1;
          if (wake_cnt_q == 10'(WAKE_CYCLES - 1)) begin
            state_q <= PM_RUN;
          end
        end
      endcase
    end
  end

  // ============================================================
  // core control outputs, all registered
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      core_halt_q <= 1'b0;
      hold_q <= 1'b0;
      run_q <= 1'b1;
      frst_q <= 1'b1;
      pcsp_q <= 1'b0;
      isvc_q <= 1'b0;
      rnext_q <= 1'b0;
      oscen_q <= 1'b1;
    end else begin
      core_halt_q <= (state_q != PM_RUN) || sleep_go;
      hold_q <= (state_q == PM_SLEEP) || sleep_go;
      run_q <= !((state_q == PM_SLEEP) || sleep_go);
      frst_q <= ext_wake || (t.overflow && state_q == PM_RUN);
      pcsp_q <= t.overflow && state_q != PM_RUN;
      oscen_q <= config_q[CFG_OSC_EN];
      // on wake completion: service only if enabled and stack has room
      isvc_q <= (state_q == PM_WAKE) && (wake_cnt_q == 10'(WAKE_CYCLES - 1)) && wake_irq_q &&
                irq_enabled && !stack_full;
      rnext_q <= (state_q == PM_WAKE) && (wake_cnt_q == 10'(WAKE_CYCLES - 1)) &&
                 !(wake_irq_q && irq_enabled && !stack_full);
    end
  end
  assign core_halt = core_halt_q;
  assign hold_state = hold_q;
  assign sys_osc_run = run_q;
  assign full_reset = frst_q;
  assign pc_sp_reset = pcsp_q;
  assign irq_service = isvc_q;
  assign resume_next = rnext_q;
  assign wdt_osc_enable = oscen_q;

  // ============================================================
  // system clock / 8 on the open-drain pin in rc mode
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      div8_q <= '0;
      osc_div_q <= 1'b1;
    end else begin
      div8_q <= div8_q + 1'b1;
      // held inverted so the enable comes straight from this flop
      osc_div_q <= !(config_q[CFG_RC_CLK] && run_q && div8_q[2]);
    end
  end
  // open drain: drive low only
  assign osc_output_pin_o = 1'b0;
  assign osc_output_pin_oe = osc_div_q;
endmodule

//--- dv/wdt_powerdown_props.sv
`timescale 1ns/1ns
// ============================================================
// port checks
module wdt_powerdown_props (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // bus
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  // core side
  input wire logic sleep_instr,
  input wire logic core_halt,
  input wire logic sys_osc_run,
  input wire logic resume_next,
  input wire logic irq_service,
  input wire logic osc_output_pin_o
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // cycles since the last resume; a resume needs a sleep and the full wake delay before it
  logic [11:0] quiet_q;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      quiet_q <= 12'h000;
    end else if (resume_next || irq_service) begin
      quiet_q <= 12'h000;
    end else if (quiet_q != 12'hFFF) begin
      quiet_q <= quiet_q + 12'h001;
    end
  end
  wait_one_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus answer late");
  wait_short_a: assert property (!avs_waitrequest |=> avs_waitrequest) else $error("answer too long");
  wait_idle_a: assert property (!$past(avs_read || avs_write) |-> avs_waitrequest) else $error("answer unasked");
  sleep_halt_a: assert property (sleep_instr && !core_halt |=> core_halt && !sys_osc_run)
    else $error("sleep did not halt");
  osc_stop_a: assert property (!sys_osc_run |-> core_halt) else $error("clock stopped while running");
  odrain_low_a: assert property (osc_output_pin_o == 1'b0) else $error("open drain drives high");
  wake_delay_a: assert property (resume_next || irq_service |-> quiet_q >= 12'h400)
    else $error("wake too early");
  resume_pulse_a: assert property (resume_next |=> !resume_next) else $error("resume not a pulse");
  wake_kind_a: assert property (!(resume_next && irq_service)) else $error("two wake kinds");
  cover property (avs_read && !avs_waitrequest);
  cover property ($rose(core_halt));
  cover property (resume_next);
  cover property (irq_service);
endmodule
bind wdt_powerdown wdt_powerdown_props wdt_powerdown_props_i (.clk, .rst, .avs_read, .avs_write,
  .avs_waitrequest, .sleep_instr, .core_halt, .sys_osc_run, .resume_next, .irq_service, .osc_output_pin_o);

//--- dv/core_model.sv
`timescale 1ns/1ns
// ============================================================
// core stand-in: instruction strobes and watchdog oscillator
module core_model (
  // clock
  input wire logic clk,
  input wire logic wdt_osc_enable,
  // strobes
  output logic sleep_instr,
  output logic clear_watchdog_single,
  output logic clear_watchdog_first,
  output logic clear_watchdog_second,
  output logic wdt_osc_tick
);
  logic [2:0] osc_q = 3'h0;
  initial begin
    sleep_instr = 1'b0;
    clear_watchdog_single = 1'b0;
    clear_watchdog_first = 1'b0;
    clear_watchdog_second = 1'b0;
    wdt_osc_tick = 1'b0;
  end
  // runs on through power-down, slower than clk so long waits never overflow it
  always @(posedge clk) begin
    osc_q <= osc_q + 3'h1;
    wdt_osc_tick <= wdt_osc_enable && osc_q == 3'h0;
  end
  // one instruction a call; the strobe stands one cycle
  task automatic issue(input int k);
    @(posedge clk);
    case (k)
      0: sleep_instr <= 1'b1;
      1: clear_watchdog_single <= 1'b1;
      2: clear_watchdog_first <= 1'b1;
      default: clear_watchdog_second <= 1'b1;
    endcase
    @(posedge clk);
    sleep_instr <= 1'b0;
    clear_watchdog_single <= 1'b0;
    clear_watchdog_first <= 1'b0;
    clear_watchdog_second <= 1'b0;
  endtask
endmodule

//--- dv/tb_wdt_powerdown.sv
`timescale 1ns/1ns
// ============================================================
// bench for watchdog and power-down
module tb_wdt_powerdown;
  import wdt_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [1:0] avs_address = 2'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata, q;
  logic avs_waitrequest, sleep_instr, clear_watchdog_single, clear_watchdog_first, clear_watchdog_second;
  logic wdt_osc_tick, core_halt, hold_state, sys_osc_run, full_reset, pc_sp_reset, irq_service, resume_next;
  logic wdt_osc_enable, osc_output_pin_o, osc_output_pin_oe, svc, prev;
  logic external_reset_pin = 1'b1;
  logic [7:0] port_a_in = 8'hFF;
  logic irq_req = 1'b0;
  logic irq_enabled = 1'b0;
  logic stack_full = 1'b0;
  int failures = 0;
  int check_count = 0;
  int resets = 0;
  int n;
  always #4 clk = ~clk;
  always @(posedge clk) resets <= resets + int'(full_reset === 1'b1);
  wdt_powerdown wdt_powerdown_i (.clk, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata,
    .avs_waitrequest, .sleep_instr, .clear_watchdog_single, .clear_watchdog_first, .clear_watchdog_second,
    .external_reset_pin, .port_a_in, .irq_req, .irq_enabled, .stack_full, .wdt_osc_tick, .core_halt, .hold_state,
    .sys_osc_run, .full_reset, .pc_sp_reset, .irq_service, .resume_next, .wdt_osc_enable, .osc_output_pin_o,
    .osc_output_pin_oe);
  core_model core_model_i (.clk, .wdt_osc_enable, .sleep_instr, .clear_watchdog_single, .clear_watchdog_first,
    .clear_watchdog_second, .wdt_osc_tick);
  // ============================================================
  // tasks
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic bus(input logic w, input logic [1:0] a, input logic [31:0] d);
    int k;
    k = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    do begin
      @(posedge clk);
      k++;
    end while (avs_waitrequest !== 1'b0 && k < 50);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk);
    if (k >= 50) failures++;
  endtask
  task automatic rd_chk(input string what, input logic [1:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    check(what, q, exp);
  endtask
  task automatic sleep;
    core_model_i.issue(0);
    @(posedge clk);
  endtask
  task automatic wait_wake;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (resume_next !== 1'b1 && irq_service !== 1'b1 && n < 2000);
    svc = irq_service;
    check("wake delay", n >= 1024 && n <= 1032, 1);
    port_a_in <= 8'hFF;
    irq_req <= 1'b0;
    repeat (4) @(posedge clk);
  endtask
  task automatic close_out;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // ============================================================
  // tests
  initial begin
    repeat (60000) @(posedge clk);
    failures++;
    close_out();
  end
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    check("osc enable", wdt_osc_enable, 1);
    rd_chk("select", ADDR_SELECT, 32'h07);
    rd_chk("config", ADDR_CONFIG, 32'h07);
    rd_chk("status", ADDR_STATUS, 32'h00);
    rd_chk("port wake", ADDR_PORTWAKE, 32'h00);
    bus(1'b1, ADDR_SELECT, 32'h05);
    rd_chk("select", ADDR_SELECT, 32'h05);
    bus(1'b1, ADDR_CONFIG, 32'h05);
    repeat (2) @(posedge clk);
    check("osc off", wdt_osc_enable, 0);
    bus(1'b1, ADDR_CONFIG, 32'h17);
    repeat (16) @(posedge clk);
    n = 0;
    prev = osc_output_pin_oe;
    repeat (64) begin
      @(posedge clk);
      n += int'(osc_output_pin_oe !== prev);
      prev = osc_output_pin_oe;
    end
    check("rc out edges", n, 16);
    bus(1'b1, ADDR_CONFIG, 32'h07);
    $display("test registers done");
    bus(1'b1, ADDR_PORTWAKE, 32'h01);
    sleep;
    check("halted", core_halt, 1);
    check("sys clock stopped", sys_osc_run, 0);
    check("state held", hold_state, 1);
    rd_chk("status asleep", ADDR_STATUS, 32'h05);
    port_a_in <= 8'hFD;
    repeat (20) @(posedge clk);
    check("masked pin", core_halt, 1);
    port_a_in <= 8'hFC;
    wait_wake;
    check("resume kind", svc, 0);
    rd_chk("flag kept", ADDR_STATUS, 32'h01);
    core_model_i.issue(1);
    rd_chk("flag cleared", ADDR_STATUS, 32'h00);
    $display("test port wake done");
    for (int i = 0; i < 3; i++) begin
      irq_enabled <= i != 1;
      stack_full <= i == 2;
      sleep;
      irq_req <= 1'b1;
      wait_wake;
      check("irq wake kind", svc, i == 0);
    end
    irq_enabled <= 1'b0;
    irq_req <= 1'b1;
    sleep;
    repeat (100) @(posedge clk);
    check("old request", core_halt, 1);
    port_a_in <= 8'hFE;
    wait_wake;
    $display("test interrupt wake done");
    bus(1'b1, ADDR_CONFIG, 32'h01);
    bus(1'b1, ADDR_SELECT, 32'h00);
    core_model_i.issue(1);
    resets = 0;
    repeat (3) begin
      repeat (1500) @(posedge clk);
      core_model_i.issue(1);
    end
    check("single clear", resets, 0);
    sleep;
    repeat (3000) @(posedge clk);
    check("stopped asleep", resets, 0);
    port_a_in <= 8'hFE;
    wait_wake;
    core_model_i.issue(1);
    bus(1'b1, ADDR_CONFIG, 32'h09);
    repeat (3) begin
      repeat (700) @(posedge clk);
      core_model_i.issue(2);
      repeat (700) @(posedge clk);
      core_model_i.issue(3);
    end
    check("paired clear", resets, 0);
    repeat (4) begin
      repeat (700) @(posedge clk);
      core_model_i.issue(2);
    end
    check("repeated first", resets > 0, 1);
    rd_chk("timeout flag", ADDR_STATUS, 32'h02);
    resets = 0;
    sleep;
    external_reset_pin <= 1'b0;
    repeat (8) @(posedge clk);
    external_reset_pin <= 1'b1;
    repeat (1100) @(posedge clk);
    check("reset wake", resets > 0, 1);
    $display("test watchdog done");
    // second reset in mid-run: registers must come back to their reset values
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    check("run after reset", sys_osc_run, 1);
    rd_chk("select after reset", ADDR_SELECT, 32'h07);
    rd_chk("status after reset", ADDR_STATUS, 32'h00);
    $display("test mid-run reset done");
    close_out();
  end
endmodule
